// [hw/atl_pkg.sv]
// package for the associative tag lookup block
package atl_pkg;
    // address resolution defaults: 32-bit key, 48-bit data
    localparam int ATL_KEY_W = 32;
    localparam int ATL_DATA_W = 48;
    localparam int ATL_DEPTH = 32;
    // spreading code configuration: 64 entries of 64 bits
    localparam int ATL_CODE_DEPTH = 64;
    localparam int ATL_CODE_W = 64;
    // tag write occupies two clock cycles
    localparam int ATL_WR_CYCLES = 2;

    typedef struct packed {
        logic hit;
        logic [ATL_DATA_W-1:0] data;
    } atl_result_t;

    typedef enum logic [2:0] {
        ATL_IDLE = 3'h1,
        ATL_WR1 = 3'h2,
        ATL_WR2 = 3'h4
    } atl_state_t;
endpackage

// [hw/atl_lookup.sv]
// associative tag store with associated-data ram and lru refill
// Notes on behaviour
// - all stored keys compared in parallel
// - any equal key drives match high
// - matching location reads data ram
// - no equal key drives match low
// - miss refill writes key and data together
// - refill fills the first free entry, else replaces least recently used entry
// - default sizes: 32-bit key, 48-bit data
// - cell header vpi/vci used as search key
// - code setup: 64 entries, 64-bit words
// - result one clock after key presented
// - key write takes two stable cycles
`timescale 1ns/100ps
`default_nettype none
module atl_lookup
#(
    parameter int KEY_W = atl_pkg::ATL_KEY_W,
    parameter int DATA_W = atl_pkg::ATL_DATA_W,
    parameter int DEPTH = atl_pkg::ATL_DEPTH,
    parameter int IDX_W = $clog2(DEPTH)
)
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic search_in,
    input wire logic [KEY_W-1:0] key_in,
    input wire logic refill_in,
    input wire logic [DATA_W-1:0] refill_data_in,
    output logic match_out,
    output logic [IDX_W-1:0] index_out,
    output logic [DATA_W-1:0] data_out,
    output logic valid_out,
    output logic busy_out
);
    import atl_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // storage
    logic [KEY_W-1:0] tag_ff [DEPTH];
    logic [DATA_W-1:0] ram_ff [DEPTH];
    logic [DEPTH-1:0] vld_ff;
    logic [IDX_W-1:0] age_ff [DEPTH];
    atl_state_t state_ff;
    logic [KEY_W-1:0] wkey_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [IDX_W-1:0] wslot_ff;

    ////////////////////////////////////////////////////////////////////
    // parallel compare and priority encode
    function automatic logic [IDX_W-1:0] enc(input logic [DEPTH-1:0] v);
        logic [IDX_W-1:0] r;
        r = '0;
        for (int i = DEPTH - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = IDX_W'(i);
            end
        end
        return r;
    endfunction

    // one compare per entry, all in the same cycle
    logic [DEPTH-1:0] hit_vec;
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : cmp
            assign hit_vec[g] = vld_ff[g] && (tag_ff[g] == key_in);
        end
    endgenerate

    wire any_hit = |hit_vec;
    wire [IDX_W-1:0] hit_idx = enc(hit_vec);

    // victim: first invalid entry, else the oldest (highest age)
    logic [DEPTH-1:0] old_vec;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : old
            assign old_vec[g] = !vld_ff[g] || (age_ff[g] == IDX_W'(DEPTH - 1));
        end
    endgenerate

    // free entries fill first; once full, the oldest entry goes
    wire all_full = &vld_ff;
    wire [IDX_W-1:0] free_slot = enc(~vld_ff);
    wire [IDX_W-1:0] lru_slot = enc(old_vec);
    wire [IDX_W-1:0] victim = all_full ? lru_slot : free_slot;

    ////////////////////////////////////////////////////////////////////
    // request decode: requests count only while idle
    wire idle = (state_ff == ATL_IDLE);
    wire do_search = idle && search_in;
    wire do_refill = idle && refill_in && !search_in;
    wire do_commit = (state_ff == ATL_WR2);

    // entry touched this cycle becomes most recent
    wire touch = (do_search && any_hit) || do_commit;
    wire [IDX_W-1:0] touch_idx = do_commit ? wslot_ff : hit_idx;
    wire [IDX_W-1:0] touch_age = age_ff[touch_idx];

    // entries more recent than the touched one age by one
    logic [DEPTH-1:0] age_up;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : upd
            assign age_up[g] = (age_ff[g] < touch_age);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // two-cycle write sequence
    atl_state_t nxt_state;
    always_comb
    begin
        case (state_ff)
            ATL_IDLE: nxt_state = do_refill ? ATL_WR1 : ATL_IDLE;
            ATL_WR1: nxt_state = ATL_WR2;
            ATL_WR2: nxt_state = ATL_IDLE;
            default: nxt_state = ATL_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_ff <= ATL_IDLE;
            vld_ff <= '0;
            wkey_ff <= '0;
            wdata_ff <= '0;
            wslot_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (do_refill)
            begin
                wkey_ff <= key_in;
                wdata_ff <= refill_data_in;
                wslot_ff <= victim;
            end
            if (do_commit)
            begin
                vld_ff[wslot_ff] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // tag and data write at the end of the write sequence
    always_ff @(posedge mclk_in)
    begin
        if (do_commit)
        begin
            tag_ff[wslot_ff] <= wkey_ff;
            ram_ff[wslot_ff] <= wdata_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // age ranks: touched entry goes to zero, younger ones age by one
    generate
        for (g = 0; g < DEPTH; g++)
        begin : ag
            always_ff @(posedge mclk_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    age_ff[g] <= IDX_W'(g);
                end
                else if (touch)
                begin
                    if (IDX_W'(g) == touch_idx)
                    begin
                        age_ff[g] <= '0;
                    end
                    else if (age_up[g])
                    begin
                        age_ff[g] <= age_ff[g] + IDX_W'(1);
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // next result words; match, index and data load only on an accepted search, valid and busy every cycle
    wire nxt_valid = do_search;
    wire nxt_busy = (nxt_state != ATL_IDLE);
    wire nxt_match = any_hit;
    wire [IDX_W-1:0] nxt_index = hit_idx;
    wire [DATA_W-1:0] nxt_data = any_hit ? ram_ff[hit_idx] : '0;

    ////////////////////////////////////////////////////////////////////
    // registered result, one cycle after the key
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            match_out <= 1'b0;
            index_out <= '0;
            data_out <= '0;
            valid_out <= 1'b0;
            busy_out <= 1'b0;
        end
        else
        begin
            valid_out <= nxt_valid;
            busy_out <= nxt_busy;
            if (do_search)
            begin
                match_out <= nxt_match;
                index_out <= nxt_index;
                data_out <= nxt_data;
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/atl_backing.sv]
// backing memory model for refills
`timescale 1ns/100ps
`default_nettype none
module atl_backing
(
    input wire logic [atl_pkg::ATL_KEY_W-1:0] key_in,
    output logic [atl_pkg::ATL_DATA_W-1:0] refill_data_out
);
    import atl_pkg::*;
    // fetched word follows the key so each entry differs
    assign refill_data_out = {16'hC3C3, key_in};
endmodule
`default_nettype wire

// [testbench/atl_lookup_chk.sv]
// assertion checker for the tag lookup
`timescale 1ns/100ps
`default_nettype none
module atl_chk #(
    parameter int KEY_W = 32,
    parameter int DATA_W = 48
)
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic search_in,
    input wire logic [KEY_W-1:0] key_in,
    input wire logic refill_in,
    input wire logic [DATA_W-1:0] refill_data_in,
    input wire logic match_out,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic valid_out,
    input wire logic busy_out
);
    logic wr_seen_ff;
    wire logic tk_s = search_in && !busy_out;
    wire logic tk_f = refill_in && !search_in && !busy_out;
    always_ff @(posedge mclk_in or posedge rst_in)
        if (rst_in)
            wr_seen_ff <= 1'b0;
        else if (tk_f)
            wr_seen_ff <= 1'b1;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    sequence fill_s;
        tk_f ##3 (search_in && key_in == $past(key_in, 3));
    endsequence
    val_lat_a: assert property (tk_s |=> valid_out)
        else $error("no result after search");
    idle_quiet_a: assert property (!tk_s |=> !valid_out)
        else $error("result without search");
    busy_len_a: assert property (tk_f |=> busy_out [*2] ##1 !busy_out)
        else $error("busy span wrong");
    busy_cause_a: assert property ($rose(busy_out) |-> $past(tk_f))
        else $error("busy without refill");
    miss_zero_a: assert property (valid_out && !match_out |-> data_out == '0)
        else $error("miss data not zero");
    res_hold_a: assert property (!valid_out |-> $stable(data_out))
        else $error("result changed");
    empty_miss_a: assert property (valid_out && !wr_seen_ff |-> !match_out)
        else $error("hit before any write");
    fill_hit_a: assert property (fill_s |=> match_out
        && data_out == $past(refill_data_in, 4)) else $error("refill lost");
endmodule
bind atl_lookup atl_chk #(.KEY_W(KEY_W), .DATA_W(DATA_W)) u_atl_chk (
    .mclk_in, .rst_in, .search_in, .key_in, .refill_in, .refill_data_in,
    .match_out, .data_out, .valid_out, .busy_out);
`default_nettype wire

// [testbench/testbench.sv]
// self-checking testbench for the tag lookup
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import atl_pkg::*;
    localparam int DEPTH = 4;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic search_in = 1'b0;
    logic refill_in = 1'b0;
    logic [ATL_KEY_W-1:0] key_in = '0;
    wire [ATL_DATA_W-1:0] refill_data_in;
    logic match_out, valid_out, busy_out;
    logic [1:0] index_out;
    logic [ATL_DATA_W-1:0] data_out;
    int n_errors = 0;
    int tests_run = 0;
    always #5 mclk_in = ~mclk_in;
    atl_backing u_atl_backing (.key_in, .refill_data_out(refill_data_in));
    atl_lookup #(.DEPTH(DEPTH)) u_atl_lookup (.mclk_in, .rst_in, .search_in,
        .key_in, .refill_in, .refill_data_in, .match_out, .index_out,
        .data_out, .valid_out, .busy_out);
    task automatic chk(input logic [63:0] seen, exp, input string msg);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask
    task automatic look(input logic [31:0] k, input logic hit,
        input logic [1:0] idx);
        @(posedge mclk_in);
        #1 search_in = 1'b1;
        key_in = k;
        @(posedge mclk_in);
        #1 search_in = 1'b0;
        chk(valid_out, 1'b1, "no result pulse");
        chk(match_out, hit, "match flag");
        chk(data_out, hit ? {16'hC3C3, k} : 48'h0, "data word");
        if (hit)
            chk(index_out, idx, "index");
    endtask
    task automatic fill(input logic [31:0] k);
        @(posedge mclk_in);
        #1 refill_in = 1'b1;
        key_in = k;
        @(posedge mclk_in);
        #1 refill_in = 1'b0;
        chk(busy_out, 1'b1, "busy after refill");
        @(posedge mclk_in);
        #1 chk(busy_out, 1'b1, "busy second cycle");
    endtask
    task automatic t_empty();
        look(32'hC0A80101, 1'b0, 2'h0);
        $display("empty search test done");
    endtask
    task automatic t_reset();
        fill(32'hC0A80101);
        look(32'hC0A80101, 1'b1, 2'h0);
        @(posedge mclk_in);
        #1 rst_in = 1'b1;
        repeat (2) @(posedge mclk_in);
        #1 rst_in = 1'b0;
        chk(valid_out, 1'b0, "valid after reset");
        chk(match_out, 1'b0, "match after reset");
        chk(data_out, 48'h0, "data after reset");
        look(32'hC0A80101, 1'b0, 2'h0);
        $display("mid-run reset test done");
    endtask
    task automatic t_lru();
        for (int i = 0; i < DEPTH; i++)
            fill(32'h0A000000 + i);
        look(32'h0A000000, 1'b1, 2'h0);
        fill(32'h0B000000);
        look(32'h0B000000, 1'b1, 2'h1);
        look(32'h0A000001, 1'b0, 2'h0);
        look(32'h0A000003, 1'b1, 2'h3);
        $display("refill and replacement test done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge mclk_in);
        #1 rst_in = 1'b0;
        t_empty();
        t_reset();
        t_lru();
        test_done();
    end
    initial
    begin
        #20000;
        n_errors++;
        test_done();
    end
endmodule
`default_nettype wire
